// >>> common/pss_pkg.sv
// Shared constants and types of the parameter set sequencer.
// Assumes one 125 MHz clock and APB word-aligned register access.
`default_nettype none
package pss_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int PSS_MAX_SETS = 64;
  localparam int PSS_FREE_MAX_SETS = 4;
  localparam int PSS_IDX_W = 6;
  localparam int PSS_TOTAL_W = 7;
  localparam int PSS_PARAM_W = 32;
  localparam logic [31:0] PSS_PARAM_DEFAULT = 32'h0000_0000;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PSS_OFF_CTRL = 8'h00;
  localparam logic [7:0] PSS_OFF_SRC = 8'h04;
  localparam logic [7:0] PSS_OFF_TOTAL = 8'h08;
  localparam logic [7:0] PSS_OFF_INDEX = 8'h0C;
  localparam logic [7:0] PSS_OFF_CMD = 8'h10;
  localparam logic [7:0] PSS_OFF_ADDRCFG = 8'h14;
  localparam logic [7:0] PSS_OFF_ACTIVE = 8'h18;
  localparam logic [7:0] PSS_OFF_STATUS = 8'h1C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PSS_CTRL_ON = 0;
  localparam int PSS_CTRL_FREE = 1;
  localparam int PSS_SRC_SEL = 0;
  localparam int PSS_SRC_LSB = 4;
  localparam int PSS_CMD_STORE = 0;
  localparam int PSS_CMD_LOAD = 1;
  localparam int PSS_CMD_STEP = 2;
  localparam int PSS_CMD_REWIND = 3;
  localparam int PSS_AC_BIT0_L2 = 0;
  localparam int PSS_AC_BIT1_L2 = 1;
  localparam int PSS_AC_INV1 = 2;
  localparam int PSS_AC_INV2 = 3;
  localparam int PSS_ST_WAIT = 8;
  localparam int PSS_ST_BUSY = 9;
  localparam int PSS_ST_RESTORE = 10;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [6:0] PSS_TOTAL_RESET = 7'h02;
  localparam int PSS_CLK_MHZ = 125;
  localparam int PSS_SETTLE_NS = 1000;
  localparam int PSS_SETTLE_CYC = (PSS_SETTLE_NS * PSS_CLK_MHZ + 999) / 1000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PSS_SRC_ALWAYS = 2'b00,
    PSS_SRC_LINE1 = 2'b01,
    PSS_SRC_LINE2 = 2'b10,
    PSS_SRC_OFF = 2'b11
  } pss_src_t;
  typedef enum logic [1:0] {
    PSS_LD_IDLE = 2'b00,
    PSS_LD_READ = 2'b01,
    PSS_LD_APPLY = 2'b10
  } pss_ld_t;
  typedef struct packed {
    logic trig;
    logic line2;
    logic line1;
  } pss_pins_t;
endpackage
`default_nettype wire

// >>> logic/pss_pin_sync.sv
// Two-flop synchroniser for the external line and trigger pins.
// Assumes the pins are asynchronous to ref_clk_in.
`default_nettype none
module pss_pin_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Pins
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] pins_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_reg <= '0;
      pins_out <= '0;
    end
    else
    begin
      meta_reg <= pins_in;
      pins_out <= meta_reg;
    end
  end
endmodule // pss_pin_sync
`default_nettype wire

// >>> logic/pss_sequencer.sv
// Parameter set sequencer: stored sets, active set, APB registers.
// Assumes frame_busy_in comes from exposure logic on the same clock.
//
// Behaviour
// - Controlled mode handles up to 64 sets, indices 0 to 63.
// - Advance source: always, line 1, line 2 or disabled, for all sets.
// - Selector picks whether source write targets advance or restart.
// - Never-stored sets within the total hold default values.
// - Store copies the active set into the indexed set.
// - Load copies the indexed set into the active set.
// - Free mode: accepted trigger samples lines, loads addressed set.
// - Free mode samples two lines above two sets, one line at two.
// - Free mode total is limited to 4 sets.
// - Free mode: a changing line drops waiting status; triggers then ignored.
// - Unchanged line states reuse the same set.
// - Disabling mid-frame finishes the frame, then restores parameters.
// - Address bit follows its line level, inverted when configured.
// - Address bit 1 is the MSB; 00 to 11 select sets 0 to 3.
`default_nettype none
module pss_sequencer #(
  parameter int PW = pss_pkg::PSS_PARAM_W,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic line1_in,
  input wire logic line2_in,
  input wire logic frame_trig_in,
  // Acquisition side
  input wire logic frame_busy_in,
  output logic [PW-1:0] active_param_out,
  output logic [pss_pkg::PSS_IDX_W-1:0] cur_index_out,
  output logic waiting_out,
  output logic trig_accept_out
);
  localparam int IW = pss_pkg::PSS_IDX_W;
  localparam int TW = pss_pkg::PSS_TOTAL_W;
  localparam logic [7:0] SETTLE = 8'(pss_pkg::PSS_SETTLE_CYC);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [TW-1:0] clamp_total(input logic [TW-1:0] t,
                                                input logic [TW-1:0] mx);
    if (t == '0)
      return TW'(1);
    else if (t > mx)
      return mx;
    else
      return t;
  endfunction

  // Level of the line that a source names, after inversion
  function automatic logic src_level(input pss_pkg::pss_src_t s,
                                     input logic l1, input logic l2,
                                     input logic always_ok);
    unique case (s)
      pss_pkg::PSS_SRC_ALWAYS: return always_ok;
      pss_pkg::PSS_SRC_LINE1: return l1;
      pss_pkg::PSS_SRC_LINE2: return l2;
      pss_pkg::PSS_SRC_OFF: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic on_reg, on_prev_reg, free_reg, sel_restart_reg;
  pss_pkg::pss_src_t adv_src_reg, rst_src_reg;
  logic [TW-1:0] total_reg;
  logic [IW-1:0] index_reg, cur_idx_reg, load_idx_reg;
  logic [3:0] addrcfg_reg;
  logic [PW-1:0] saved_reg;
  logic store_pend_reg, load_pend_reg, step_pend_reg, rewind_pend_reg;
  logic restore_pend_reg;
  logic [7:0] settle_reg;
  pss_pkg::pss_ld_t ld_reg;
  pss_pkg::pss_pins_t pins, pins_prev_reg;
  logic [2:0] pins_raw;
  logic [PW-1:0] rd_data;

  // ----------------------------------------
  // Pin synchronisers and set storage
  // ----------------------------------------
  pss_pin_sync #(.W(3)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .pins_in({frame_trig_in, line2_in, line1_in}),
    .pins_out(pins_raw)
  );
  assign pins = pss_pkg::pss_pins_t'(pins_raw);

  logic store_now;
  assign store_now = store_pend_reg && ld_reg == pss_pkg::PSS_LD_IDLE;

  pss_set_store #(.DW(PW)) u_store (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(store_now),
    .wr_addr_in(index_reg),
    .wr_data_in(active_param_out),
    .rd_addr_in(load_idx_reg),
    .rd_data_out(rd_data)
  );

  // ----------------------------------------
  // Decode of lines, triggers and events
  // ----------------------------------------
  logic lv1, lv2, bit0, bit1, line_change, trig_rise, accept;
  logic [TW-1:0] eff_total;
  logic [IW-1:0] next_idx, free_addr;
  logic adv_q, rst_q, go_load, restore_now, en_rise;
  logic [IW-1:0] go_idx;

  assign lv1 = pins.line1 ^ addrcfg_reg[pss_pkg::PSS_AC_INV1];
  assign lv2 = pins.line2 ^ addrcfg_reg[pss_pkg::PSS_AC_INV2];
  assign bit0 = addrcfg_reg[pss_pkg::PSS_AC_BIT0_L2] ? lv2 : lv1;
  assign bit1 = addrcfg_reg[pss_pkg::PSS_AC_BIT1_L2] ? lv2 : lv1;
  // free mode total capped at four
  assign eff_total = free_reg ?
    clamp_total(total_reg, TW'(pss_pkg::PSS_FREE_MAX_SETS)) :
    clamp_total(total_reg, TW'(pss_pkg::PSS_MAX_SETS));
  // bit 1 is the most significant
  // one line only at two sets
  assign free_addr = (eff_total > TW'(2)) ? IW'({bit1, bit0}) :
                     (eff_total == TW'(2)) ? IW'(bit0) : '0;
  // step with wrap after last set
  assign next_idx = (TW'(cur_idx_reg) + TW'(1) >= eff_total) ? '0 :
                    cur_idx_reg + IW'(1);
  // one advance source for every set
  assign adv_q = src_level(adv_src_reg, lv1, lv2, 1'b1);
  // Restart has no always-active choice
  assign rst_q = src_level(rst_src_reg, lv1, lv2, 1'b0);
  assign line_change = free_reg && on_reg &&
    (pins.line1 != pins_prev_reg.line1 || pins.line2 != pins_prev_reg.line2);
  assign trig_rise = pins.trig && !pins_prev_reg.trig;
  assign accept = trig_rise && waiting_out;
  assign en_rise = on_reg && !on_prev_reg;
  // restore only once the frame is out
  assign restore_now = restore_pend_reg && !frame_busy_in &&
                       ld_reg == pss_pkg::PSS_LD_IDLE;

  always_comb
  begin
    go_load = 1'b0;
    go_idx = '0;
    if (ld_reg == pss_pkg::PSS_LD_IDLE && !restore_pend_reg)
    begin
      if (en_rise && !free_reg)
        go_load = 1'b1;
      else if (accept && on_reg && free_reg)
      begin
        go_load = 1'b1;
        go_idx = free_addr;
      end
      else if (accept && on_reg && rst_q)
        go_load = 1'b1;
      else if (accept && on_reg && adv_q)
      begin
        go_load = 1'b1;
        go_idx = next_idx;
      end
      else if (on_reg && !free_reg && rewind_pend_reg)
        go_load = 1'b1;
      else if (on_reg && !free_reg && step_pend_reg)
      begin
        go_load = 1'b1;
        go_idx = next_idx;
      end
      else if (load_pend_reg && !store_pend_reg)
      begin
        go_load = 1'b1;
        go_idx = index_reg;
      end
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic setup, wr_acc;
  logic [31:0] rd_mux;
  logic rd_err;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite && !pslverr;

  always_comb
  begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'b00 || paddr > AW'(pss_pkg::PSS_OFF_STATUS))
      rd_err = 1'b1;
    else
    begin
      unique case (8'(paddr))
        pss_pkg::PSS_OFF_CTRL:
        begin
          rd_mux[pss_pkg::PSS_CTRL_ON] = on_reg;
          rd_mux[pss_pkg::PSS_CTRL_FREE] = free_reg;
        end
        pss_pkg::PSS_OFF_SRC:
        begin
          rd_mux[pss_pkg::PSS_SRC_SEL] = sel_restart_reg;
          rd_mux[pss_pkg::PSS_SRC_LSB +: 2] = sel_restart_reg ?
            rst_src_reg : adv_src_reg;
        end
        pss_pkg::PSS_OFF_TOTAL: rd_mux[TW-1:0] = total_reg;
        pss_pkg::PSS_OFF_INDEX: rd_mux[IW-1:0] = index_reg;
        pss_pkg::PSS_OFF_CMD: rd_mux = '0;
        pss_pkg::PSS_OFF_ADDRCFG: rd_mux[3:0] = addrcfg_reg;
        pss_pkg::PSS_OFF_ACTIVE: rd_mux[PW-1:0] = active_param_out;
        pss_pkg::PSS_OFF_STATUS:
        begin
          rd_mux[IW-1:0] = cur_idx_reg;
          rd_mux[pss_pkg::PSS_ST_WAIT] = waiting_out;
          rd_mux[pss_pkg::PSS_ST_BUSY] = ld_reg != pss_pkg::PSS_LD_IDLE;
          rd_mux[pss_pkg::PSS_ST_RESTORE] = restore_pend_reg;
        end
      endcase
    end
  end

  // Answer is ready in the first access cycle: no wait states
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && rd_err;
      prdata <= (setup && !pwrite && !rd_err) ? rd_mux : '0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      on_reg <= 1'b0;
      free_reg <= 1'b0;
      sel_restart_reg <= 1'b0;
      adv_src_reg <= pss_pkg::PSS_SRC_OFF;
      rst_src_reg <= pss_pkg::PSS_SRC_OFF;
      total_reg <= pss_pkg::PSS_TOTAL_RESET;
      index_reg <= '0;
      addrcfg_reg <= '0;
    end
    else if (wr_acc)
    begin
      unique case (8'(paddr))
        pss_pkg::PSS_OFF_CTRL:
        begin
          on_reg <= pwdata[pss_pkg::PSS_CTRL_ON];
          free_reg <= pwdata[pss_pkg::PSS_CTRL_FREE];
        end
        pss_pkg::PSS_OFF_SRC:
        begin
          sel_restart_reg <= pwdata[pss_pkg::PSS_SRC_SEL];
          if (pwdata[pss_pkg::PSS_SRC_SEL])
            rst_src_reg <= pss_pkg::pss_src_t'(
              pwdata[pss_pkg::PSS_SRC_LSB +: 2]);
          else
            adv_src_reg <= pss_pkg::pss_src_t'(
              pwdata[pss_pkg::PSS_SRC_LSB +: 2]);
        end
        // total kept within 1 to 64
        pss_pkg::PSS_OFF_TOTAL:
          total_reg <= clamp_total(pwdata[TW-1:0],
                                   TW'(pss_pkg::PSS_MAX_SETS));
        pss_pkg::PSS_OFF_INDEX: index_reg <= pwdata[IW-1:0];
        pss_pkg::PSS_OFF_ADDRCFG: addrcfg_reg <= pwdata[3:0];
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Command flags: a new command beats its own clear
  // ----------------------------------------
  logic cmd_wr;
  assign cmd_wr = wr_acc && 8'(paddr) == pss_pkg::PSS_OFF_CMD;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      store_pend_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      step_pend_reg <= 1'b0;
      rewind_pend_reg <= 1'b0;
    end
    else
    begin
      store_pend_reg <= (cmd_wr && pwdata[pss_pkg::PSS_CMD_STORE]) ||
                        (store_pend_reg && !store_now);
      load_pend_reg <= (cmd_wr && pwdata[pss_pkg::PSS_CMD_LOAD]) ||
                       (load_pend_reg && !(go_load && go_idx == index_reg
                        && !on_reg));
      step_pend_reg <= on_reg && !free_reg &&
        ((cmd_wr && pwdata[pss_pkg::PSS_CMD_STEP]) ||
         (step_pend_reg && !(go_load && !accept && !rewind_pend_reg)));
      rewind_pend_reg <= on_reg && !free_reg &&
        ((cmd_wr && pwdata[pss_pkg::PSS_CMD_REWIND]) ||
         (rewind_pend_reg && !(go_load && !accept)));
    end
  end

  // ----------------------------------------
  // Load engine and active set
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ld_reg <= pss_pkg::PSS_LD_IDLE;
      load_idx_reg <= '0;
      cur_idx_reg <= '0;
    end
    else
    begin
      unique case (ld_reg)
        pss_pkg::PSS_LD_IDLE:
          if (go_load)
          begin
            ld_reg <= pss_pkg::PSS_LD_READ;
            load_idx_reg <= go_idx;
            cur_idx_reg <= go_idx;
          end
        pss_pkg::PSS_LD_READ: ld_reg <= pss_pkg::PSS_LD_APPLY;
        pss_pkg::PSS_LD_APPLY: ld_reg <= pss_pkg::PSS_LD_IDLE;
        default: ld_reg <= pss_pkg::PSS_LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      active_param_out <= pss_pkg::PSS_PARAM_DEFAULT;
    else if (ld_reg == pss_pkg::PSS_LD_APPLY)
      active_param_out <= rd_data;
    else if (restore_now)
      active_param_out <= saved_reg;
    else if (wr_acc && 8'(paddr) == pss_pkg::PSS_OFF_ACTIVE)
      active_param_out <= pwdata[PW-1:0];
  end

  // ----------------------------------------
  // Enable, disable and restore
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      on_prev_reg <= 1'b0;
      saved_reg <= pss_pkg::PSS_PARAM_DEFAULT;
      restore_pend_reg <= 1'b0;
    end
    else
    begin
      on_prev_reg <= on_reg;
      if (en_rise)
        saved_reg <= active_param_out;
      if (!on_reg && on_prev_reg)
        restore_pend_reg <= 1'b1;
      else if (restore_now || en_rise)
        restore_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Waiting status and trigger acceptance
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pins_prev_reg <= '0;
      settle_reg <= '0;
      waiting_out <= 1'b0;
      trig_accept_out <= 1'b0;
      cur_index_out <= '0;
    end
    else
    begin
      pins_prev_reg <= pins;
      // hold off a settle time after a line moves
      if (line_change)
        settle_reg <= SETTLE;
      else if (settle_reg != '0)
        settle_reg <= settle_reg - 8'h01;
      waiting_out <= !frame_busy_in && !line_change && settle_reg == '0 &&
                     !go_load && ld_reg == pss_pkg::PSS_LD_IDLE;
      trig_accept_out <= accept;
      cur_index_out <= cur_idx_reg;
    end
  end
endmodule // pss_sequencer
`default_nettype wire

// >>> logic/pss_set_store.sv
// Storage for the sequence sets, with one synchronous read port.
// Assumes the caller gives the read address a cycle before using data.
`default_nettype none
module pss_set_store #(
  parameter int DEPTH = pss_pkg::PSS_MAX_SETS,
  parameter int AW = pss_pkg::PSS_IDX_W,
  parameter int DW = pss_pkg::PSS_PARAM_W,
  parameter logic [DW-1:0] DEFAULT = pss_pkg::PSS_PARAM_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  // Read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem [DEPTH];
  logic [DEPTH-1:0] stored_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (wr_en_in)
      mem[wr_addr_in] <= wr_data_in;
  end

  // Valid bits replace a memory reset
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      stored_reg <= '0;
    else if (wr_en_in)
      stored_reg[wr_addr_in] <= 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rd_data_out <= DEFAULT;
    else if (wr_en_in && wr_addr_in == rd_addr_in)
      rd_data_out <= wr_data_in;
    else if (stored_reg[rd_addr_in])
      rd_data_out <= mem[rd_addr_in];
    else
      rd_data_out <= DEFAULT;
  end
endmodule // pss_set_store
`default_nettype wire

// >>> tb/pss_checker.sv
// Port-level checker of the parameter set sequencer, bound into it.
// Assumes one clock domain and active-low asynchronous reset.
`default_nettype none
module pss_checker #(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  input wire logic waiting_out,
  input wire logic trig_accept_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic setup;
  assign setup = psel && !penable;
  chk_apb_ready: assert property (setup |=> pready)
    else $error("pready missing after setup");
  chk_apb_lone: assert property (pready |-> $past(setup) && penable)
    else $error("pready outside an access cycle");
  chk_err_unmapped: assert property (setup && paddr > 8'h1C |=> pslverr)
    else $error("no error for unmapped address");
  chk_err_unaligned: assert property (setup && paddr[1:0] != 2'h0
    |=> pslverr) else $error("no error for unaligned address");
  chk_err_none: assert property (setup && paddr[1:0] == 2'h0
    && paddr <= 8'h1C |=> !pslverr) else $error("error on mapped address");
  chk_rd_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_acc_waiting: assert property (trig_accept_out |->
    $past(waiting_out) || $past(waiting_out, 2))
    else $error("trigger taken while not waiting");
  chk_acc_pulse: assert property (trig_accept_out |=> !trig_accept_out)
    else $error("accept pulse too long");
  chk_load_busy: assert property (trig_accept_out |-> ##[0:3] !waiting_out)
    else $error("waiting kept during load");
  cov_accept: cover property (trig_accept_out);
  cov_error: cover property (pslverr);
  cov_wait_drop: cover property ($fell(waiting_out));
endmodule // pss_checker
bind pss_sequencer pss_checker #(.AW(AW)) chk (
  .ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .waiting_out(waiting_out),
  .trig_accept_out(trig_accept_out)
);
`default_nettype wire

// >>> tb/pss_equip_model.sv
// External equipment: address lines, frame trigger, exposure busy.
// Assumes the caller runs one frame at a time.
`default_nettype none
module pss_equip_model (
  // Clock and status
  input wire logic ref_clk_in,
  input wire logic waiting_in,
  // Pins
  output logic line1_out,
  output logic line2_out,
  output logic trig_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pin tasks
  // ----------------------------------------
  initial
  begin
    line1_out = 1'b0;
    line2_out = 1'b0;
    trig_out = 1'b0;
    busy_out = 1'b0;
  end
  task automatic set_lines(input logic l1, input logic l2);
    @(posedge ref_clk_in);
    line1_out <= l1;
    line2_out <= l2;
  endtask
  task automatic frame();
    int n;
    n = 0;
    repeat (126) @(posedge ref_clk_in);
    while (waiting_in !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    trig_out <= 1'b1;
    // Busy only after the synced edge is taken
    repeat (4) @(posedge ref_clk_in);
    busy_out <= 1'b1;
    repeat (126) @(posedge ref_clk_in);
    trig_out <= 1'b0;
    busy_out <= 1'b0;
    @(posedge ref_clk_in);
  endtask
endmodule // pss_equip_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the parameter set sequencer.
// Assumes the checker is bound in and the equipment model drives pins.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and helpers
  // ----------------------------------------
  logic ref_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr, er;
  logic line1, line2, trig, busy, waiting, accept;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, act, rd, base, e, lq, v[4];
  logic [5:0] idx;
  logic [3:0] fc[4] = '{4'h2, 4'hE, 4'h1, 4'h9};
  logic [31:0] ft[4] = '{32'h4, 32'h8, 32'h4, 32'h2};
  logic [31:0] tw[3] = '{32'h0, 32'h40, 32'h7F};
  logic [31:0] te[3] = '{32'h1, 32'h40, 32'h40};
  int n_fail = 0, samples_checked = 0, cyc = 0;
  pss_sequencer dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line1_in(line1), .line2_in(line2),
    .frame_trig_in(trig), .frame_busy_in(busy),
    .active_param_out(act), .cur_index_out(idx),
    .waiting_out(waiting), .trig_accept_out(accept));
  pss_equip_model eq (.ref_clk_in(ref_clk_in), .waiting_in(waiting),
    .line1_out(line1), .line2_out(line2), .trig_out(trig),
    .busy_out(busy));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction
  function automatic logic [1:0] f_addr(input logic [3:0] c,
    input logic l1, input logic l2, input logic [31:0] t);
    logic b0;
    logic b1;
    b0 = (c[0] ? l2 : l1) ^ (c[0] ? c[3] : c[2]);
    b1 = (c[1] ? l2 : l1) ^ (c[1] ? c[3] : c[2]);
    return (t > 32'h2) ? {b1, b0} : {1'b0, b0};
  endfunction
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("unexpected at %0t: word %h not %h", $time, g, x);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic x);
    samples_checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("unexpected at %0t: flag %b not %b", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do
      @(posedge ref_clk_in);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp_word(rd, x);
  endtask
  task automatic load(input logic [31:0] i);
    wr(8'h0C, i);
    wr(8'h10, 32'h2);
    repeat (4) @(posedge ref_clk_in);
  endtask
  // ----------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // Ceiling well above the roughly 6000 cycles of the run
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    {rstn_in, psel, penable, pwrite, paddr, pwdata} = '0;
    lq = 32'h0001_6FE7;
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    rdc(8'h08, 32'h2);
    rdc(8'h04, 32'h30);
    apb(1'b1, 8'h02, 32'h1);
    cmp_bit(er, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    cmp_bit(er, 1'b1);
    foreach (tw[i])
    begin
      wr(8'h08, tw[i]);
      rdc(8'h08, te[i]);
    end
    wr(8'h18, 32'hA5A5_5A5A);
    load(32'd63);
    cmp_word(act, 32'h0);
    wr(8'h08, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      lq = nxt(lq);
      v[i] = lq;
      wr(8'h18, v[i]);
      wr(8'h0C, 32'(i));
      wr(8'h10, 32'h1);
    end
    for (int i = 3; i >= 0; i--)
    begin
      load(32'(i));
      cmp_word(act, v[i]);
    end
    $display("test registers done");
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h00);
    wr(8'h00, 32'h1);
    repeat (4) @(posedge ref_clk_in);
    cmp_word(act, v[0]);
    for (int k = 1; k < 5; k++)
    begin
      eq.frame();
      cmp_word(act, v[k % 3]);
      cmp_word(32'(idx), 32'(k % 3));
    end
    wr(8'h10, 32'h8);
    repeat (6) @(posedge ref_clk_in);
    cmp_word(act, v[0]);
    wr(8'h10, 32'h4);
    repeat (6) @(posedge ref_clk_in);
    cmp_word(act, v[1]);
    // off while configuring, restart on line 1 only
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h11);
    rdc(8'h04, 32'h11);
    wr(8'h04, 32'h00);
    wr(8'h00, 32'h1);
    eq.frame();
    cmp_word(act, v[1]);
    eq.set_lines(1'b1, 1'b0);
    eq.frame();
    cmp_word(act, v[0]);
    wr(8'h00, 32'h0);
    $display("test controlled done");
    for (int c = 0; c < 4; c++)
    begin
      lq = nxt(lq);
      base = lq;
      wr(8'h00, 32'h2);
      wr(8'h08, ft[c]);
      wr(8'h14, 32'(fc[c]));
      wr(8'h18, base);
      wr(8'h00, 32'h3);
      eq.set_lines(~line1, ~line2);
      repeat (8) @(posedge ref_clk_in);
      cmp_bit(waiting, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
        // Third frame keeps the lines to reuse the set
        if (k != 2)
        begin
          lq = nxt(lq);
          eq.set_lines(lq[0], lq[1]);
        end
        // Pins update after this step, so use the drawn bits
        e = v[f_addr(fc[c], lq[0], lq[1], ft[c])];
        if (k < 3)
        begin
          eq.frame();
          cmp_word(act, e);
        end
        else
        begin
          fork
            eq.frame();
            begin
              repeat (140) @(posedge ref_clk_in);
              wr(8'h00, 32'h2);
              cmp_word(act, e);
            end
          join
          repeat (4) @(posedge ref_clk_in);
          cmp_word(act, base);
        end
      end
    end
    $display("test free selection done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
